// *** design/dcs_top.sv ***
// Purpose: Debug serial clock select, mode control, rate sync reply and
//          core-clock resource access of the background debug controller.
// Assumes: ref_clk is the core clock; debug clocks arrive as ticks.
// Notes:   Pin is open-drain style: out is low whenever oe is high.
`timescale 1ns/1ps
`include "dcs_params.svh"

// How it works
// - Serial tick comes from the constant or fast clock, per select bit.
// - Constant clock selected: link timing ignores core clock changes.
// - Fast clock selected: link timing follows the PLL-derived clock.
// - Internal resource accesses always run on the core clock.
// - After the switch delay, all link timing uses the newly selected clock.
// - Three modes, disabled, enabled, active, gated by security and mode.
// - Active mode halts the processor for full resource access.
// - Normal single chip, unsecured: controller leaves reset disabled.
// - Special single chip: controller leaves reset in active mode.
// - A rate sync command lets the host measure the link rate.
// - Status access and sync work in any state; erase and ack commands in any mode, but are refused while an access is pending.
module dcs_top
  import dcs_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rstn,
  // Debug clock ticks
  input  wire logic           constant_debug_clock,
  input  wire logic           fast_debug_clock,
  // Device status
  input  wire logic           special_single_chip_mode,
  input  wire logic           device_secure,
  // Debug pin
  input  wire logic           debug_pin_in,
  output logic                debug_pin_out,
  output logic                debug_pin_oe,
  // Decoded commands from the serial side
  input  wire logic           cmd_valid,
  input  dcs_cmd_class_t      cmd_class,
  input  wire logic           cmd_write,
  input  wire logic [23:0]    cmd_addr,
  input  wire logic [31:0]    cmd_wdata,
  input  wire logic           csr_wr,
  input  wire logic [7:0]     csr_wdata,
  input  wire logic           enter_active,
  input  wire logic           exit_active,
  // Command answers
  output logic                cmd_accept,
  output logic                cmd_reject,
  output logic                cmd_done,
  output logic [31:0]         cmd_rdata,
  output logic [7:0]          csr_rdata,
  // Internal resource bus, core clock
  output logic                res_req,
  output logic                res_write,
  output logic [23:0]         res_addr,
  output logic [31:0]         res_wdata,
  input  wire logic           res_ack,
  input  wire logic [31:0]    res_rdata,
  // Status
  output logic                debug_serial_interface,
  output dcs_mode_t           debug_mode,
  output logic                cpu_halt,
  output logic                sync_seen
);

  dcs_ctl_if ctl ();

  logic                  sel_req_q;
  logic                  cmd_accept_q;
  logic                  cmd_reject_q;
  logic                  cmd_done_q;
  logic [31:0]           cmd_rdata_q;
  logic [7:0]            csr_rdata_q;
  logic                  res_req_q;
  logic                  res_write_q;
  logic [23:0]           res_addr_q;
  logic [31:0]           res_wdata_q;
  logic                  si_q;
  dcs_mode_t             mode_q;
  logic                  halt_q;
  dcs_sync_t             sync_q;
  dcs_sync_t             sync_d;
  logic [`DCS_CNT_W-1:0] sync_cnt_q;
  logic [`DCS_CNT_W-1:0] sync_cnt_d;
  logic                  pin_oe_q;
  logic                  sync_seen_q;

  // Whether a command class may run in a given mode
  function automatic logic class_ok(input dcs_cmd_class_t c,
                                    input dcs_mode_t m);
    logic ok;
    ok = 1'b0;
    unique case (c)
      DCS_CMD_ALWAYS:  ok = 1'b1;
      DCS_CMD_ENABLED: ok = (m != DCS_DISABLED);
      DCS_CMD_ACTIVE:  ok = (m == DCS_ACTIVE);
      default:         ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Saturating tick counter step
  function automatic logic [`DCS_CNT_W-1:0] cnt_inc(
    input logic [`DCS_CNT_W-1:0] v);
    return (v == `DCS_CNT_MAX) ? v : v + 1'b1;
  endfunction

  // Hook-up of the submodule carrier
  assign ctl.const_tick   = constant_debug_clock;
  assign ctl.fast_tick    = fast_debug_clock;
  assign ctl.sel_req      = sel_req_q;
  assign ctl.special_mode = special_single_chip_mode;
  assign ctl.secure       = device_secure;
  assign ctl.enable_set   = csr_wr && csr_wdata[`DCS_CSR_EN_BIT];
  assign ctl.enable_clr   = csr_wr && !csr_wdata[`DCS_CSR_EN_BIT];
  assign ctl.enter_active = enter_active;
  assign ctl.exit_active  = exit_active;

  dcs_clk_switch u_clk_switch (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ctl     (ctl.clk_sw)
  );

  dcs_mode_ctl u_mode_ctl (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ctl     (ctl.mode_ctl)
  );

  // Command decode
  wire cmd_busy  = res_req_q;
  wire cmd_ok    = cmd_valid && !cmd_busy && class_ok(cmd_class, ctl.mode);
  wire cmd_bad   = cmd_valid && !cmd_ok;
  wire res_fin   = res_req_q && res_ack;
  wire tick      = ctl.si_tick;
  wire pin_low   = !debug_pin_in;
  wire [7:0] csr_view = {2'b00, ctl.mode, ctl.cur_sel, ctl.switching,
                         (ctl.mode != DCS_DISABLED), sel_req_q};

  // Output map
  assign cmd_accept             = cmd_accept_q;
  assign cmd_reject             = cmd_reject_q;
  assign cmd_done               = cmd_done_q;
  assign cmd_rdata              = cmd_rdata_q;
  assign csr_rdata              = csr_rdata_q;
  assign res_req                = res_req_q;
  assign res_write              = res_write_q;
  assign res_addr               = res_addr_q;
  assign res_wdata              = res_wdata_q;
  assign debug_serial_interface = si_q;
  assign debug_mode             = mode_q;
  assign cpu_halt               = halt_q;
  assign debug_pin_oe           = pin_oe_q;
  assign debug_pin_out          = 1'b0;
  assign sync_seen              = sync_seen_q;

  // Clock select bit, written by status access in any state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sel_req_q <= `DCS_SEL_RESET;
    end else if (csr_wr) begin
      sel_req_q <= csr_wdata[`DCS_CSR_SEL_BIT];
    end
  end

  // Status byte readback
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      csr_rdata_q <= `DCS_CSR_RESET;
    end else begin
      csr_rdata_q <= csr_view;
    end
  end

  // Accept or refuse commands against the mode
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_accept_q <= 1'b0;
      cmd_reject_q <= 1'b0;
    end else begin
      cmd_accept_q <= cmd_ok;
      cmd_reject_q <= cmd_bad;
    end
  end

  // Resource request held until acknowledged, on the core clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      res_req_q   <= 1'b0;
      res_write_q <= 1'b0;
      res_addr_q  <= '0;
      res_wdata_q <= '0;
    end else if (cmd_ok) begin
      res_req_q   <= 1'b1;
      res_write_q <= cmd_write;
      res_addr_q  <= cmd_addr;
      res_wdata_q <= cmd_wdata;
    end else if (res_fin) begin
      res_req_q <= 1'b0;
    end
  end

  // Completion and read data
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_done_q  <= 1'b0;
      cmd_rdata_q <= '0;
    end else begin
      cmd_done_q <= res_fin;
      if (res_fin && !res_write_q) cmd_rdata_q <= res_rdata;
    end
  end

  // Status mirrors
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      si_q   <= 1'b0;
      mode_q <= DCS_DISABLED;
      halt_q <= 1'b0;
    end else begin
      si_q   <= tick;
      mode_q <= ctl.mode;
      halt_q <= ctl.halt;
    end
  end

  // Rate sync: measure host low pulse, then answer with a low pulse
  always_comb begin
    sync_d     = sync_q;
    sync_cnt_d = sync_cnt_q;
    unique case (sync_q)
      DCS_SYNC_IDLE: begin
        sync_cnt_d = '0;
        if (pin_low) sync_d = DCS_SYNC_LOW;
      end
      DCS_SYNC_LOW: begin
        if (!pin_low) begin
          sync_cnt_d = '0;
          sync_d = (sync_cnt_q >= `DCS_SYNC_DETECT_TICKS) ? DCS_SYNC_WAIT
                                                          : DCS_SYNC_IDLE;
        end else if (tick) begin
          sync_cnt_d = cnt_inc(sync_cnt_q);
        end
      end
      DCS_SYNC_WAIT: begin
        if (tick) begin
          if (sync_cnt_q == `DCS_SYNC_DELAY_TICKS - 1'b1) begin
            sync_cnt_d = '0;
            sync_d     = DCS_SYNC_DRIVE;
          end else begin
            sync_cnt_d = sync_cnt_q + 1'b1;
          end
        end
      end
      DCS_SYNC_DRIVE: begin
        if (tick) begin
          if (sync_cnt_q == `DCS_SYNC_RESP_TICKS - 1'b1) begin
            sync_cnt_d = '0;
            sync_d     = DCS_SYNC_IDLE;
          end else begin
            sync_cnt_d = sync_cnt_q + 1'b1;
          end
        end
      end
    endcase
  end

  // Rate sync registers and pin drive
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_q      <= DCS_SYNC_IDLE;
      sync_cnt_q  <= '0;
      pin_oe_q    <= 1'b0;
      sync_seen_q <= 1'b0;
    end else begin
      sync_q      <= sync_d;
      sync_cnt_q  <= sync_cnt_d;
      pin_oe_q    <= (sync_d == DCS_SYNC_DRIVE);
      sync_seen_q <= (sync_q == DCS_SYNC_LOW) && (sync_d == DCS_SYNC_WAIT);
    end
  end

  a_always_accept: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cmd_valid && !res_req_q && cmd_class == DCS_CMD_ALWAYS |=> cmd_accept)
    else $error("always-available command was refused");
  a_disabled_reject: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    cmd_valid && ctl.mode == DCS_DISABLED && cmd_class != DCS_CMD_ALWAYS
    |=> cmd_reject && ($past(res_req_q) || !res_req))
    else $error("command ran while controller disabled");
  a_halt_active: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ctl.mode == DCS_ACTIVE |=> cpu_halt)
    else $error("processor not halted in active mode");
  a_req_holds: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    res_req && !res_ack |=> res_req && $stable(res_addr))
    else $error("resource request dropped before acknowledge");
  a_sync_reply: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(debug_pin_oe) |-> $past(sync_q) == DCS_SYNC_WAIT && !debug_pin_out)
    else $error("sync reply without a measured request");
  a_select_sticky: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    csr_wr |=> sel_req_q == $past(csr_wdata[`DCS_CSR_SEL_BIT]))
    else $error("clock select not taken from status write");

endmodule

// *** design/dcs_params.svh ***
// Purpose: Timing counts, field positions and reset values of the
//          debug serial clock select block.
// Assumes: Counts are in ticks of the serial-interface clock.
// Notes:   Included by its bare name.
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

// Old-clock ticks that must pass before the new source takes over
`define DCS_SWITCH_CYCLES     150
// Counter width for every tick counter in the block
`define DCS_CNT_W             8
// Least low time on the pin, in ticks, that counts as a rate request
`define DCS_SYNC_DETECT_TICKS 8'h10
// Ticks from pin release to start of the rate reply
`define DCS_SYNC_DELAY_TICKS  8'h10
// Length of the low rate reply, in ticks
`define DCS_SYNC_RESP_TICKS   8'h80
// Saturation value of the low-time counter
`define DCS_CNT_MAX           8'hFF

// Control-status byte fields
`define DCS_CSR_SEL_BIT       0
`define DCS_CSR_EN_BIT        1
`define DCS_CSR_SW_BIT        2
`define DCS_CSR_SRC_BIT       3
`define DCS_CSR_MODE_LSB      4
`define DCS_CSR_MODE_MSB      5

// Reset values
`define DCS_SEL_RESET         1'b0
`define DCS_CSR_RESET         8'h00

`endif

// *** design/dcs_pkg.sv ***
// Purpose: Types shared by the debug serial clock select modules.
// Assumes: Nothing beyond the params header.
// Notes:   Modes, command classes and rate-sync states.
package dcs_pkg;

  // Debug controller modes
  typedef enum logic [1:0] {
    DCS_DISABLED,
    DCS_ENABLED,
    DCS_ACTIVE
  } dcs_mode_t;

  // Access class a command needs
  typedef enum logic [1:0] {
    DCS_CMD_ALWAYS,
    DCS_CMD_ENABLED,
    DCS_CMD_ACTIVE
  } dcs_cmd_class_t;

  // Rate synchronisation sequence
  typedef enum logic [1:0] {
    DCS_SYNC_IDLE,
    DCS_SYNC_LOW,
    DCS_SYNC_WAIT,
    DCS_SYNC_DRIVE
  } dcs_sync_t;

endpackage

// *** design/dcs_ctl_if.sv ***
// Purpose: Carries clock select and mode signals inside the block.
// Assumes: All signals on ref_clk.
// Notes:   One modport per submodule.
`timescale 1ns/1ps
interface dcs_ctl_if;
  import dcs_pkg::*;
  logic      const_tick;
  logic      fast_tick;
  logic      sel_req;
  logic      si_tick;
  logic      switching;
  logic      cur_sel;
  logic      special_mode;
  logic      secure;
  logic      enable_set;
  logic      enable_clr;
  logic      enter_active;
  logic      exit_active;
  dcs_mode_t mode;
  logic      halt;

  // Clock switch side
  modport clk_sw (input const_tick, fast_tick, sel_req,
                  output si_tick, switching, cur_sel);
  // Mode controller side
  modport mode_ctl (input special_mode, secure, enable_set, enable_clr,
                    enter_active, exit_active,
                    output mode, halt);
endinterface

// *** design/dcs_clk_switch.sv ***
// Purpose: Selects the serial-interface tick from two debug clocks.
// Assumes: Both sources arrive as one-cycle ticks on ref_clk.
// Notes:   Swaps only on an old-source tick after the switch delay.
`timescale 1ns/1ps
`include "dcs_params.svh"
module dcs_clk_switch
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control
  dcs_ctl_if.clk_sw ctl
);
  localparam int CNT_W   = `DCS_CNT_W;
  localparam int SW_LAST = `DCS_SWITCH_CYCLES - 1;
  localparam logic [`DCS_CNT_W-1:0] CNT_LAST = CNT_W'(SW_LAST);

  logic                  cur_sel_q;
  logic                  busy_q;
  logic [`DCS_CNT_W-1:0] cnt_q;
  logic                  si_tick_q;
  wire                   old_tick;
  wire                   start;
  wire                   swap;

  // Old source tick, start and end of a switch
  assign old_tick = cur_sel_q ? ctl.fast_tick : ctl.const_tick;
  assign start    = !busy_q && (ctl.sel_req != cur_sel_q);
  assign swap     = busy_q && old_tick && (cnt_q == CNT_LAST);
  assign ctl.si_tick   = si_tick_q;
  assign ctl.switching = busy_q;
  assign ctl.cur_sel   = cur_sel_q;

  // Delay counter on old-clock ticks, swap at a tick boundary
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_sel_q <= `DCS_SEL_RESET;
      busy_q    <= 1'b0;
      cnt_q     <= '0;
      si_tick_q <= 1'b0;
    end else begin
      si_tick_q <= old_tick;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
      end else if (swap) begin
        busy_q    <= 1'b0;
        cur_sel_q <= ~cur_sel_q;
      end else if (busy_q && old_tick) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  a_switch_delay: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $changed(cur_sel_q) |-> $past(cnt_q) == CNT_LAST && $past(old_tick))
    else $error("clock source changed before switch delay");
  a_switch_start: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !busy_q && ctl.sel_req != cur_sel_q |=> busy_q)
    else $error("select change did not start a switch");
endmodule

// *** design/dcs_mode_ctl.sv ***
// Purpose: Disabled, enabled and active modes of the debug controller.
// Assumes: Operating mode and security are steady around reset.
// Notes:   Reset mode is taken at the first edge after release.
`timescale 1ns/1ps
`include "dcs_params.svh"
module dcs_mode_ctl
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control
  dcs_ctl_if.mode_ctl ctl
);
  logic      init_q;
  dcs_mode_t mode_q;
  dcs_mode_t mode_d;
  logic      halt_q;

  assign ctl.mode = mode_q;
  assign ctl.halt = halt_q;

  // Next mode
  always_comb begin
    mode_d = mode_q;
    if (!init_q) begin
      mode_d = ctl.special_mode ? DCS_ACTIVE : DCS_DISABLED;
    end else begin
      unique case (mode_q)
        DCS_DISABLED: begin
          if (ctl.enable_set && !ctl.secure) mode_d = DCS_ENABLED;
        end
        DCS_ENABLED: begin
          if (ctl.enable_clr) mode_d = DCS_DISABLED;
          else if (ctl.enter_active) mode_d = DCS_ACTIVE;
        end
        DCS_ACTIVE: begin
          if (ctl.exit_active) mode_d = DCS_ENABLED;
        end
        default: mode_d = DCS_DISABLED;
      endcase
    end
  end

  // Mode and processor halt registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      init_q <= 1'b0;
      mode_q <= DCS_DISABLED;
      halt_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      mode_q <= mode_d;
      halt_q <= (mode_d == DCS_ACTIVE);
    end
  end

  a_reset_mode: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !init_q |=> mode_q == ($past(ctl.special_mode) ? DCS_ACTIVE
                                                   : DCS_DISABLED))
    else $error("wrong mode out of reset");
  a_secure_stays: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    init_q && mode_q == DCS_DISABLED && ctl.secure |=> mode_q == DCS_DISABLED)
    else $error("secure device left disabled mode");
endmodule

// *** dv/dcs_host_model.sv ***
// Purpose: Host side of the one-pin debug link, rate sync only.
// Assumes: Pin has a pull-up; the host only ever pulls it low.
// Notes:   Counts link ticks, so results are in link clock periods.
`timescale 1ns/1ps
module dcs_host_model (
  // Clock and link
  input  wire logic ref_clk,
  input  wire logic link_tick,
  input  wire logic pin_level,
  // Host pin drive
  output logic      host_low
);
  initial host_low = 1'b0;

  // Pull low for low_ticks, release, then time the device reply
  task automatic rate_sync(input int low_ticks, output int reply);
    int n;
    int w;
    n = 0;
    w = 0;
    reply = 0;
    @(posedge ref_clk);
    host_low <= 1'b1;
    while (n < low_ticks) begin
      @(posedge ref_clk);
      if (link_tick) n++;
    end
    host_low <= 1'b0;
    @(posedge ref_clk);
    // Bounded wait for the device to pull low
    while (pin_level && w < 400) begin
      @(posedge ref_clk);
      w++;
    end
    // Reply length in link ticks, also bounded
    while (!pin_level && w < 2000) begin
      @(posedge ref_clk);
      w++;
      if (link_tick) reply++;
    end
  endtask
endmodule

// *** dv/dcs_top_tb.sv ***
// Purpose: Self-checking bench of the debug serial clock select block.
// Assumes: Debug clock ticks are made here in the ref_clk domain.
// Notes:   Command answers are checked against a queue of notes.
`timescale 1ns/1ps
module dcs_top_tb;
  import dcs_pkg::*;
  typedef struct packed {logic [1:0] k; logic [31:0] d;} dcs_note_t;

  logic           ref_clk = 1'b0;
  logic           rstn = 1'b0;
  logic           constant_debug_clock = 1'b0;
  logic           fast_debug_clock = 1'b0;
  logic           special_single_chip_mode = 1'b0;
  logic           device_secure = 1'b0;
  logic           cmd_valid = 1'b0;
  dcs_cmd_class_t cmd_class = DCS_CMD_ALWAYS;
  logic           cmd_write = 1'b0;
  logic [23:0]    cmd_addr = 24'h0;
  logic [31:0]    cmd_wdata = 32'h0;
  logic           csr_wr = 1'b0;
  logic [7:0]     csr_wdata = 8'h00;
  logic           enter_active = 1'b0;
  logic           exit_active = 1'b0;
  logic           res_ack = 1'b0;
  logic [31:0]    res_rdata = 32'h0;
  logic           debug_pin_out, debug_pin_oe, cmd_accept, cmd_reject;
  logic           cmd_done, res_req, res_write, debug_serial_interface;
  logic           cpu_halt, sync_seen, host_low, c1, c2, f1, f2;
  logic [31:0]    cmd_rdata, res_wdata, cyc = 32'h0;
  logic [7:0]     csr_rdata;
  logic [23:0]    res_addr;
  dcs_mode_t      debug_mode;
  int             n_fail = 0, n_compared = 0, n_sync = 0, seed = 10949;
  int             src = 0, nold = 0, age = 0, ack_dly = 2, wcnt = 0;
  int             i, r;
  dcs_note_t      q[$];
  // Open-drain pin with pull-up
  wire            pin_level = !(host_low || debug_pin_oe);

  dcs_top dcs_top_i (.ref_clk, .rstn, .constant_debug_clock,
    .fast_debug_clock, .special_single_chip_mode, .device_secure,
    .debug_pin_in(pin_level), .debug_pin_out, .debug_pin_oe, .cmd_valid,
    .cmd_class, .cmd_write, .cmd_addr, .cmd_wdata, .csr_wr, .csr_wdata,
    .enter_active, .exit_active, .cmd_accept, .cmd_reject, .cmd_done,
    .cmd_rdata, .csr_rdata, .res_req, .res_write, .res_addr, .res_wdata,
    .res_ack, .res_rdata, .debug_serial_interface, .debug_mode, .cpu_halt,
    .sync_seen);
  dcs_host_model dcs_host_model_i (.ref_clk, .link_tick(fast_debug_clock),
    .pin_level, .host_low);

  always #20 ref_clk = ~ref_clk;

  // Ticks never coincide; delayed copies for the serial tick check
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    constant_debug_clock <= (cyc % 6 == 4);
    fast_debug_clock <= cyc[0];
    c1 <= constant_debug_clock;
    c2 <= c1;
    f1 <= fast_debug_clock;
    f2 <= f1;
  end

  // Resource responder, acks after ack_dly cycles
  always @(posedge ref_clk) begin
    wcnt <= (res_req && !res_ack) ? wcnt + 1 : 0;
    res_ack <= res_req && !res_ack && (wcnt == ack_dly);
    res_rdata <= {8'h5A, res_addr};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Compare one command answer with the oldest note
  task automatic take(input logic [1:0] k, input logic [31:0] d);
    dcs_note_t n;
    if (q.size() == 0) begin
      n_fail++;
      $display("[FAIL] %0t unexpected command answer", $time);
    end else begin
      n = q.pop_front();
      chk({30'h0, (n.k == 2'd3) ? 2'd2 : n.k}, {30'h0, k});
      if (n.k == 2'd2) chk(d, n.d);
      if (n.k == 2'd3) chk(res_wdata, n.d);
      if (n.k[1]) chk(res_write, n.k[0]);
    end
  endtask

  // Watch answers, sync pulses and the selected serial tick
  always @(negedge ref_clk) begin
    if (cmd_accept === 1'b1) take(2'd0, 32'h0);
    if (cmd_reject === 1'b1) take(2'd1, 32'h0);
    if (cmd_done === 1'b1) take(2'd2, cmd_rdata);
    if (sync_seen === 1'b1) n_sync++;
    age = rstn ? age + 1 : 0;
    if (!rstn) src = 0;
    if (age > 4) begin
      if (src == 1 && debug_serial_interface && f2) begin
        chk(nold >= 149 && nold <= 152, 1);
        src = 2;
      end else begin
        chk(debug_serial_interface, (src == 2) ? f2 : c2);
        if (src == 1 && c2) nold++;
      end
    end
  end

  // Issue one command and note the answers it should get
  task automatic cmd(input dcs_cmd_class_t c, input logic w, input logic ok);
    dcs_note_t n;
    logic [23:0] a;
    logic [31:0] wd;
    a = 24'($random(seed));
    wd = $random(seed);
    n = '{ok ? 2'd0 : 2'd1, 32'h0};
    if (!ok) q.insert((q.size() == 0) ? 0 : q.size() - 1, n);
    else q.push_back(n);
    n = '{w ? 2'd3 : 2'd2, w ? wd : {8'h5A, a}};
    if (ok) q.push_back(n);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_class <= c;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= wd;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
  endtask

  // Wait until all noted answers came, then space by one cycle
  task automatic idle;
    for (int j = 0; j < 60 && q.size() != 0; j++) @(posedge ref_clk);
    chk(32'(q.size()), 32'h0);
    q.delete();
    @(posedge ref_clk);
  endtask

  task automatic do_reset(input logic spec, input logic sec);
    @(posedge ref_clk);
    special_single_chip_mode <= spec;
    device_secure <= sec;
    rstn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic csr(input logic [7:0] v);
    @(posedge ref_clk);
    csr_wr <= 1'b1;
    csr_wdata <= v;
    @(posedge ref_clk);
    csr_wr <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic act(input logic on);
    @(posedge ref_clk);
    enter_active <= on;
    exit_active <= !on;
    @(posedge ref_clk);
    enter_active <= 1'b0;
    exit_active <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic final_report;
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Normal mode, then secured, then special mode with switch and sync
  initial begin
    do_reset(1'b0, 1'b0);
    chk(debug_mode, DCS_DISABLED);
    chk(cpu_halt, 1'b0);
    chk(csr_rdata, 8'h00);
    cmd(DCS_CMD_ENABLED, 1'b0, 1'b0);
    idle;
    cmd(DCS_CMD_ALWAYS, 1'b0, 1'b1);
    idle;
    csr(8'h02);
    chk(debug_mode, DCS_ENABLED);
    chk(csr_rdata[1], 1'b1);
    cmd(DCS_CMD_ENABLED, 1'b1, 1'b1);
    idle;
    cmd(DCS_CMD_ACTIVE, 1'b0, 1'b0);
    idle;
    act(1'b1);
    chk(debug_mode, DCS_ACTIVE);
    chk(cpu_halt, 1'b1);
    ack_dly = 6;
    cmd(DCS_CMD_ACTIVE, 1'b1, 1'b1);
    cmd(DCS_CMD_ALWAYS, 1'b0, 1'b0);
    idle;
    act(1'b0);
    chk(cpu_halt, 1'b0);
    csr(8'h00);
    chk(debug_mode, DCS_DISABLED);
    do_reset(1'b0, 1'b1);
    csr(8'h02);
    chk(debug_mode, DCS_DISABLED);
    cmd(DCS_CMD_ALWAYS, 1'b1, 1'b1);
    idle;
    do_reset(1'b1, 1'b0);
    chk(debug_mode, DCS_ACTIVE);
    chk(cpu_halt, 1'b1);
    for (i = 0; i < 6; i++) begin
      ack_dly = 1 + ($unsigned($random(seed)) % 4);
      cmd(dcs_cmd_class_t'(i % 3), i[0], 1'b1);
      idle;
    end
    nold = 0;
    src = 1;
    csr(8'h01);
    for (i = 0; i < 1500 && src != 2; i++) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(src, 2);
    chk(csr_rdata[3:2], 2'b10);
    dcs_host_model_i.rate_sync(20, r);
    chk(r >= 127 && r <= 129, 1);
    chk(n_sync, 1);
    dcs_host_model_i.rate_sync(10, r);
    chk(r, 0);
    chk(n_sync, 1);
    chk(debug_pin_out, 1'b0);
    final_report;
  end

  // Watchdog against a hang
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_fail++;
    final_report;
  end
endmodule
